/* File: rtl/acm_clock_ctrl.sv */
// Top of the audio serial port clock configuration and monitor block.
// Assumes a simple synchronous register port behind the control interface.
`timescale 1ns/1ps
`default_nettype none
module acm_clock_ctrl #(
  parameter int BCLK_HALF = acm_pkg::ACM_BCLK_HALF
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [7:0]       reg_addr,
  input  wire logic             reg_wr,
  input  wire logic [7:0]       reg_wdata,
  output logic      [7:0]       reg_rdata,
  input  wire logic             bus_role_select,
  input  wire logic             auto_config_off,
  input  wire logic             auto_config_pll_off,
  input  wire logic [2:0]       master_clock_fixed_freq,
  input  wire logic             bclk_in,
  output logic                  bclk_out,
  output logic                  bclk_oe,
  input  wire logic             frame_sync_in,
  output logic                  frame_sync_out,
  output logic                  frame_sync_oe,
  output logic      [3:0]       eff_frame_rate,
  output logic      [3:0]       eff_bitclk_ratio,
  output acm_pkg::acm_root_t    root_select,
  output logic                  mclk_from_ratio,
  output logic      [2:0]       mclk_fixed_code,
  output logic      [11:0]      mclk_per_frame
);
  acm_link_if link ();

  logic [7:0]  cfg_r,     cfg_nxt;
  logic [7:0]  src_r,     src_nxt;
  logic [7:0]  rdata_r,   rdata_nxt;
  logic [3:0]  rate_o_r,  rate_o_nxt;
  logic [3:0]  ratio_o_r, ratio_o_nxt;
  acm_pkg::acm_root_t root_r, root_nxt;
  logic        mfr_r,     mfr_nxt;
  logic [2:0]  mfix_r,    mfix_nxt;
  logic [11:0] mpf_r,     mpf_nxt;
  logic        bclk_o_r,  bclk_o_nxt;
  logic        bclk_e_r,  bclk_e_nxt;
  logic        fs_o_r,    fs_o_nxt;
  logic        fs_e_r,    fs_e_nxt;

  logic        master;
  logic        auto_on;
  logic        slave_auto;
  logic [3:0]  prog_rate;
  logic [3:0]  prog_ratio;
  logic [2:0]  mclk_ratio_code;
  logic [3:0]  safe_ratio;

  assign master          = bus_role_select;
  assign auto_on         = ~auto_config_off;
  assign slave_auto      = ~master & auto_on;
  assign prog_rate       = cfg_r[acm_pkg::ACM_RATE_HI:acm_pkg::ACM_RATE_LO];
  assign prog_ratio      = cfg_r[acm_pkg::ACM_RATIO_HI:acm_pkg::ACM_RATIO_LO];
  assign mclk_ratio_code = src_r[acm_pkg::ACM_MRAT_HI:acm_pkg::ACM_MRAT_LO];
  // Reserved ratio codes would index past the table; fall back to the reset ratio
  assign safe_ratio = (prog_ratio < acm_pkg::ACM_RATIO_CODES) ? prog_ratio
                                                             : acm_pkg::ACM_RATIO_DEF;

  // Bus as seen by the monitor: own clocks as master, pins as slave
  assign link.bclk_bus  = master ? bclk_o_r : bclk_in;
  assign link.frame_sync_bus = master ? fs_o_r : frame_sync_in;
  assign link.gen_en    = master;
  assign link.gen_inv   = src_r[acm_pkg::ACM_SRC_INV];
  assign link.gen_ratio = safe_ratio;

  acm_bus_monitor u_mon (
    .clk  (clk),
    .nrst (nrst),
    .link (link)
  );

  acm_frame_sync_gen #(
    .HALF (BCLK_HALF)
  ) u_gen (
    .clk  (clk),
    .nrst (nrst),
    .link (link)
  );

  // Register file
  always_comb begin
    cfg_nxt   = cfg_r;
    src_nxt   = src_r;
    rdata_nxt = 8'h00;
    if (reg_wr) begin
      unique case (reg_addr)
        acm_pkg::ACM_OFS_RATE_RATIO: cfg_nxt = reg_wdata;
        // Reserved bits are stored as written; software keeps them zero
        acm_pkg::ACM_OFS_CLK_SOURCE: src_nxt = reg_wdata;
        default: begin
          cfg_nxt = cfg_r;
        end
      endcase
    end
    unique case (reg_addr)
      acm_pkg::ACM_OFS_RATE_RATIO: rdata_nxt = cfg_r;
      acm_pkg::ACM_OFS_MON_STATUS: rdata_nxt = {link.det_rate, link.det_ratio};
      acm_pkg::ACM_OFS_CLK_SOURCE: rdata_nxt = src_r;
      default:                     rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r   <= acm_pkg::ACM_RST_RATE_RATIO;
      src_r   <= acm_pkg::ACM_RST_CLK_SOURCE;
      rdata_r <= 8'h00;
    end else begin
      cfg_r   <= cfg_nxt;
      src_r   <= src_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Effective clock configuration
  always_comb begin
    if (slave_auto) begin
      // Programmed values play no part; the bus decides
      rate_o_nxt  = link.det_rate;
      ratio_o_nxt = link.det_ratio;
    end else begin
      rate_o_nxt  = prog_rate;
      ratio_o_nxt = prog_ratio;
    end
    root_nxt = acm_pkg::ACM_ROOT_PLL;
    if (slave_auto && auto_config_pll_off) begin
      root_nxt = src_r[acm_pkg::ACM_SRC_ROOT] ? acm_pkg::ACM_ROOT_MCLK
                                               : acm_pkg::ACM_ROOT_BCLK;
    end
    mfr_nxt  = auto_on & src_r[acm_pkg::ACM_SRC_FMODE];
    mfix_nxt = master_clock_fixed_freq;
    mpf_nxt  = 12'h000;
    // Ratio applies in master mode or with master clock as slave root
    if (master || root_nxt == acm_pkg::ACM_ROOT_MCLK) begin
      mpf_nxt = acm_pkg::ACM_MCLK_RATIO_VAL[mclk_ratio_code];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rate_o_r  <= acm_pkg::ACM_RST_RATE_RATIO[7:4];
      ratio_o_r <= acm_pkg::ACM_RST_RATE_RATIO[3:0];
      root_r    <= acm_pkg::ACM_ROOT_PLL;
      mfr_r     <= 1'b0;
      mfix_r    <= 3'h0;
      mpf_r     <= 12'h000;
    end else begin
      rate_o_r  <= rate_o_nxt;
      ratio_o_r <= ratio_o_nxt;
      root_r    <= root_nxt;
      mfr_r     <= mfr_nxt;
      mfix_r    <= mfix_nxt;
      mpf_r     <= mpf_nxt;
    end
  end

  // Pin drivers
  always_comb begin
    bclk_o_nxt = link.gen_bclk;
    fs_o_nxt   = link.gen_frame_sync;
    bclk_e_nxt = master;
    fs_e_nxt   = master;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_o_r <= 1'b0;
      fs_o_r   <= 1'b0;
      bclk_e_r <= 1'b0;
      fs_e_r   <= 1'b0;
    end else begin
      bclk_o_r <= bclk_o_nxt;
      fs_o_r   <= fs_o_nxt;
      bclk_e_r <= bclk_e_nxt;
      fs_e_r   <= fs_e_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign bclk_out         = bclk_o_r;
  assign bclk_oe          = bclk_e_r;
  assign frame_sync_out   = fs_o_r;
  assign frame_sync_oe    = fs_e_r;
  assign eff_frame_rate   = rate_o_r;
  assign eff_bitclk_ratio = ratio_o_r;
  assign root_select      = root_r;
  assign mclk_from_ratio  = mfr_r;
  assign mclk_fixed_code  = mfix_r;
  assign mclk_per_frame   = mpf_r;
endmodule
`default_nettype wire

/* File: rtl/acm_pkg.sv */
// Constants, register map and decode tables of the audio serial port clock block.
// Assumes a single 100 MHz clock; all other files refer to names here as acm_pkg::name.
package acm_pkg;

  localparam logic [7:0] ACM_OFS_RATE_RATIO = 8'h14;
  localparam logic [7:0] ACM_OFS_MON_STATUS = 8'h15;
  localparam logic [7:0] ACM_OFS_CLK_SOURCE = 8'h16;

  localparam logic [7:0] ACM_RST_RATE_RATIO = 8'h48;
  localparam logic [7:0] ACM_RST_MON_STATUS = 8'hff;
  localparam logic [7:0] ACM_RST_CLK_SOURCE = 8'h10;

  localparam int ACM_RATE_HI   = 7;
  localparam int ACM_RATE_LO   = 4;
  localparam int ACM_RATIO_HI  = 3;
  localparam int ACM_RATIO_LO  = 0;
  localparam int ACM_SRC_ROOT  = 7;
  localparam int ACM_SRC_FMODE = 6;
  localparam int ACM_MRAT_HI   = 5;
  localparam int ACM_MRAT_LO   = 3;
  localparam int ACM_SRC_INV   = 1;

  localparam logic [3:0] ACM_CODE_INVALID = 4'hf;
  localparam logic [3:0] ACM_RATE_CODES   = 4'h9;
  localparam logic [3:0] ACM_RATIO_CODES  = 4'hd;
  localparam logic [3:0] ACM_RATIO_DEF    = 4'h8;

  // Frame period window in 10 ns cycles per rate code, 44.1k family max to 48k family min, +-2 %
  localparam logic [14:0] ACM_PER_MIN [9] = '{15'h2fda, 15'h17ed, 15'h0ff3, 15'h0bf6,
                                              15'h07f9, 15'h03fc, 15'h01fe, 15'h00ff, 15'h007f};
  localparam logic [14:0] ACM_PER_MAX [9] = '{15'h3635, 15'h1b1a, 15'h1211, 15'h0d8d,
                                              15'h0909, 15'h0484, 15'h0242, 15'h0121, 15'h0090};

  localparam logic [11:0] ACM_RATIO_VAL [13] = '{12'h010, 12'h018, 12'h020, 12'h030, 12'h040,
                                                 12'h060, 12'h080, 12'h0c0, 12'h100, 12'h180,
                                                 12'h200, 12'h400, 12'h800};

  localparam logic [11:0] ACM_MCLK_RATIO_VAL [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
                                                     12'h300, 12'h400, 12'h600, 12'h900};

  // Master mode bit clock half period in system clocks
  localparam int ACM_BCLK_HALF = 4;

  typedef enum logic [2:0] {
    ACM_ROOT_PLL  = 3'b001,
    ACM_ROOT_BCLK = 3'b010,
    ACM_ROOT_MCLK = 3'b100
  } acm_root_t;

endpackage

/* File: rtl/acm_link_if.sv */
// Carrier between the clock control top and its monitor and frame sync generator.
// Assumes all three sit on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface acm_link_if;
  logic       bclk_bus;
  logic       frame_sync_bus;
  logic [3:0] det_rate;
  logic [3:0] det_ratio;
  logic       gen_en;
  logic       gen_inv;
  logic [3:0] gen_ratio;
  logic       gen_bclk;
  logic       gen_frame_sync;

  modport mon (input bclk_bus, input frame_sync_bus, output det_rate, output det_ratio);
  modport gen (input gen_en, input gen_inv, input gen_ratio, output gen_bclk, output gen_frame_sync);
  modport top (output bclk_bus, output frame_sync_bus, input det_rate, input det_ratio,
               output gen_en, output gen_inv, output gen_ratio, input gen_bclk, input gen_frame_sync);
endinterface
`default_nettype wire

/* File: rtl/acm_bus_monitor.sv */
// Measures frame period and bit clocks per frame on the serial bus.
// Assumes bus levels synchronous to clk and bit clock below a quarter of clk.
`timescale 1ns/1ps
`default_nettype none
module acm_bus_monitor (
  input  wire logic clk,
  input  wire logic nrst,
  acm_link_if.mon   link
);
  logic        bclk_q_r,  bclk_q_nxt;
  logic        fs_q_r,    fs_q_nxt;
  logic [14:0] per_r,     per_nxt;
  logic [11:0] bits_r,    bits_nxt;
  logic        armed_r,   armed_nxt;
  logic [3:0]  rate_r,    rate_nxt;
  logic [3:0]  ratio_r,   ratio_nxt;
  logic [3:0]  rate_cls;
  logic [3:0]  ratio_cls;
  logic        fs_rise;
  logic        bclk_rise;

  assign fs_rise   = link.frame_sync_bus & ~fs_q_r;
  assign bclk_rise = link.bclk_bus & ~bclk_q_r;

  always_comb begin
    rate_cls  = acm_pkg::ACM_CODE_INVALID;
    ratio_cls = acm_pkg::ACM_CODE_INVALID;
    for (int i = 0; i < 9; i++) begin
      if (per_r >= acm_pkg::ACM_PER_MIN[i] && per_r <= acm_pkg::ACM_PER_MAX[i]) begin
        rate_cls = 4'(i);
      end
    end
    for (int j = 0; j < 13; j++) begin
      if (bits_r == acm_pkg::ACM_RATIO_VAL[j]) begin
        ratio_cls = 4'(j);
      end
    end
  end

  always_comb begin
    bclk_q_nxt = link.bclk_bus;
    fs_q_nxt   = link.frame_sync_bus;
    per_nxt    = per_r;
    bits_nxt   = bits_r;
    armed_nxt  = armed_r;
    rate_nxt   = rate_r;
    ratio_nxt  = ratio_r;
    if (fs_rise) begin
      // First edge after reset or timeout only starts a measurement
      if (armed_r) begin
        rate_nxt  = rate_cls;
        ratio_nxt = ratio_cls;
      end
      armed_nxt = 1'b1;
      per_nxt   = 15'h0001;
      bits_nxt  = {11'h000, bclk_rise};
    end else begin
      if (per_r != 15'h7fff) begin
        per_nxt = per_r + 15'h0001;
      end
      if (bclk_rise && bits_r != 12'hfff) begin
        bits_nxt = bits_r + 12'h001;
      end
      if (per_r > acm_pkg::ACM_PER_MAX[0]) begin
        // Frame sync lost: report invalid rather than a stale rate
        armed_nxt = 1'b0;
        rate_nxt  = acm_pkg::ACM_CODE_INVALID;
        ratio_nxt = acm_pkg::ACM_CODE_INVALID;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bclk_q_r <= 1'b0;
      fs_q_r   <= 1'b0;
      per_r    <= 15'h0000;
      bits_r   <= 12'h000;
      armed_r  <= 1'b0;
      rate_r   <= acm_pkg::ACM_RST_MON_STATUS[7:4];
      ratio_r  <= acm_pkg::ACM_RST_MON_STATUS[3:0];
    end else begin
      bclk_q_r <= bclk_q_nxt;
      fs_q_r   <= fs_q_nxt;
      per_r    <= per_nxt;
      bits_r   <= bits_nxt;
      armed_r  <= armed_nxt;
      rate_r   <= rate_nxt;
      ratio_r  <= ratio_nxt;
    end
  end

  assign link.det_rate  = rate_r;
  assign link.det_ratio = ratio_r;
endmodule
`default_nettype wire

/* File: rtl/acm_frame_sync_gen.sv */
// Master mode bit clock and frame sync generator.
// Assumes the ratio code is already checked and stable while enabled.
`timescale 1ns/1ps
`default_nettype none
module acm_frame_sync_gen #(
  parameter int HALF = acm_pkg::ACM_BCLK_HALF
) (
  input  wire logic clk,
  input  wire logic nrst,
  acm_link_if.gen   link
);
  logic [7:0]  div_r,  div_nxt;
  logic        bclk_r, bclk_nxt;
  logic [11:0] bit_r,  bit_nxt;
  logic        fs_r,   fs_nxt;
  logic [11:0] flen;
  logic        tick;
  logic        move_edge;

  assign flen = acm_pkg::ACM_RATIO_VAL[link.gen_ratio];
  assign tick = (div_r == 8'(HALF - 1));
  // Normal: frame sync moves on falling bit clock, inverted on rising
  assign move_edge = tick & (link.gen_inv ? ~bclk_r : bclk_r);

  always_comb begin
    div_nxt  = tick ? 8'h00 : div_r + 8'h01;
    bclk_nxt = tick ? ~bclk_r : bclk_r;
    bit_nxt  = bit_r;
    fs_nxt   = fs_r;
    if (move_edge) begin
      bit_nxt = (bit_r >= flen - 12'h001) ? 12'h000 : bit_r + 12'h001;
      fs_nxt  = (bit_r >= flen - 12'h001);
    end
    if (!link.gen_en) begin
      div_nxt  = 8'h00;
      bclk_nxt = 1'b0;
      bit_nxt  = 12'h000;
      fs_nxt   = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r  <= 8'h00;
      bclk_r <= 1'b0;
      bit_r  <= 12'h000;
      fs_r   <= 1'b0;
    end else begin
      div_r  <= div_nxt;
      bclk_r <= bclk_nxt;
      bit_r  <= bit_nxt;
      fs_r   <= fs_nxt;
    end
  end

  assign link.gen_bclk  = bclk_r;
  assign link.gen_frame_sync = fs_r;
endmodule
`default_nettype wire

/* File: testbench/acm_clock_ctrl_asserts.sv */
// Concurrent checks on the ports of the clock control top.
// Assumes it is bound to acm_clock_ctrl and sees nothing but its ports.
`timescale 1ns/1ps
`default_nettype none
module acm_clock_ctrl_asserts #(
  parameter int BCLK_HALF = acm_pkg::ACM_BCLK_HALF
) (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic [7:0]          reg_addr,
  input wire logic                reg_wr,
  input wire logic [7:0]          reg_wdata,
  input wire logic [7:0]          reg_rdata,
  input wire logic                bus_role_select,
  input wire logic                auto_config_off,
  input wire logic                auto_config_pll_off,
  input wire logic [2:0]          master_clock_fixed_freq,
  input wire logic                bclk_in,
  input wire logic                bclk_out,
  input wire logic                bclk_oe,
  input wire logic                frame_sync_in,
  input wire logic                frame_sync_out,
  input wire logic                frame_sync_oe,
  input wire logic [3:0]          eff_frame_rate,
  input wire logic [3:0]          eff_bitclk_ratio,
  input wire logic [2:0]          root_select,
  input wire logic                mclk_from_ratio,
  input wire logic [2:0]          mclk_fixed_code,
  input wire logic [11:0]         mclk_per_frame
);
  localparam logic [11:0] MRAT [8] = '{12'h040, 12'h100, 12'h180, 12'h200,
                                       12'h300, 12'h400, 12'h600, 12'h900};
  logic [7:0]  cfg_r, cfg_nxt, src_r, src_nxt;
  logic        fs_r, seen_r, seen_nxt, pll_slv, mroot, fmode;
  logic [11:0] mexp;

  // Shadows of the writable registers, rebuilt from the write port
  always_comb begin
    cfg_nxt  = (reg_wr && reg_addr == 8'h14) ? reg_wdata : cfg_r;
    src_nxt  = (reg_wr && reg_addr == 8'h16) ? reg_wdata : src_r;
    seen_nxt = bclk_oe && (seen_r || (fs_r && !frame_sync_out));
    pll_slv  = !bus_role_select && !auto_config_off && auto_config_pll_off;
    mroot    = pll_slv && src_r[7];
    fmode    = !auto_config_off && src_r[6];
    mexp     = (bus_role_select || mroot) ? MRAT[src_r[5:3]] : 12'h000;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_r  <= 8'h48;
      src_r  <= 8'h10;
      fs_r   <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      cfg_r  <= cfg_nxt;
      src_r  <= src_nxt;
      fs_r   <= frame_sync_out;
      seen_r <= seen_nxt;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // First frame after turn-on is skipped, its edge pairing is not settled
  sequence s_frame_start;
    seen_r && $rose(frame_sync_out);
  endsequence

  AST_RD_RATE_RATIO: assert property (reg_addr == 8'h14 |=> reg_rdata == $past(cfg_r))
    else $error("rate ratio readback wrong");
  AST_RD_CLK_SOURCE: assert property (reg_addr == 8'h16 |=> reg_rdata == $past(src_r))
    else $error("clock source readback wrong");
  AST_RD_UNMAPPED: assert property (!(reg_addr inside {8'h14, 8'h15, 8'h16}) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
  AST_STATUS_CODES: assert property (reg_addr == 8'h15 |=>
    (reg_rdata[7:4] <= 4'h8 || reg_rdata[7:4] == 4'hf) &&
    (reg_rdata[3:0] <= 4'hc || reg_rdata[3:0] == 4'hf)) else $error("status code reserved");
  AST_EFF_PROGRAMMED: assert property ((auto_config_off || bus_role_select) |=>
    {eff_frame_rate, eff_bitclk_ratio} == $past(cfg_r)) else $error("programmed codes unused");
  AST_ROOT_SELECT: assert property (1'b1 |=> root_select == ($past(mroot) ?
    acm_pkg::ACM_ROOT_MCLK : ($past(pll_slv) ? acm_pkg::ACM_ROOT_BCLK : acm_pkg::ACM_ROOT_PLL)))
    else $error("root clock select wrong");
  AST_MCLK_MODE: assert property (1'b1 |=> mclk_from_ratio == $past(fmode))
    else $error("master clock mode wrong");
  AST_MCLK_RATIO: assert property (1'b1 |=> mclk_per_frame == $past(mexp))
    else $error("master clock ratio wrong");
  AST_PIN_DIRECTION: assert property (1'b1 |=> bclk_oe == $past(bus_role_select) &&
    frame_sync_oe == $past(bus_role_select)) else $error("pin direction wrong");
  AST_FRAME_SYNC_EDGE: assert property (s_frame_start |->
    (src_r[1] ? $rose(bclk_out) : $fell(bclk_out))) else $error("frame sync edge wrong");
endmodule
`default_nettype wire

/* File: testbench/acm_host_model.sv */
// Host audio processor clocking the serial bus while the block is slave.
// Assumes it is only heard when the block's pin enables are low.
`timescale 1ns/1ps
`default_nettype none
module acm_host_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [11:0] half,
  input  wire logic [11:0] bits,
  output logic             bclk,
  output logic             frame_sync
);
  int cnt = 0;

  // Pins settle to idle at the first edge, well inside reset
  always @(posedge clk) begin
    #1;
    // Clocks stand still while run is low
    if (!run) begin
      cnt   = 0;
      bclk  = 1'b0;
      frame_sync = 1'b0;
    end else begin
      frame_sync = cnt < 2 * int'(half);
      bclk  = (cnt % (2 * int'(half))) >= int'(half);
      cnt   = (cnt + 1 >= 2 * int'(half) * int'(bits)) ? 0 : cnt + 1;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/acm_clock_ctrl_test.sv */
// Self-checking bench for the audio serial port clock control top.
// Assumes the host model owns the bus pins whenever the block does not drive them.
`timescale 1ns/1ps
`default_nettype none
module acm_clock_ctrl_test;
  localparam int HALF = 2;
  logic               clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0;
  logic [7:0]         reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic               bus_role_select = 1'b0, auto_config_off = 1'b1, auto_config_pll_off = 1'b0;
  logic [2:0]         master_clock_fixed_freq = 3'h2, mclk_fixed_code;
  logic               bclk_out, bclk_oe, frame_sync_out, frame_sync_oe, mclk_from_ratio;
  logic [3:0]         eff_frame_rate, eff_bitclk_ratio;
  acm_pkg::acm_root_t root_select;
  logic [11:0]        mclk_per_frame, h_half = 12'h010, h_bits = 12'h040;
  logic               h_run = 1'b0, h_bclk, h_fs;
  int                 fails = 0, tests_run = 0;
  wire                bclk_pin = bclk_oe ? bclk_out : h_bclk;
  wire                fs_pin = frame_sync_oe ? frame_sync_out : h_fs;

  always #5 clk = ~clk;

  acm_host_model host (.clk(clk), .run(h_run), .half(h_half), .bits(h_bits), .bclk(h_bclk),
    .frame_sync(h_fs));

  acm_clock_ctrl #(.BCLK_HALF(HALF)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .bus_role_select(bus_role_select), .auto_config_off(auto_config_off),
    .auto_config_pll_off(auto_config_pll_off), .master_clock_fixed_freq(master_clock_fixed_freq),
    .bclk_in(bclk_pin), .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_sync_in(fs_pin),
    .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
    .eff_frame_rate(eff_frame_rate), .eff_bitclk_ratio(eff_bitclk_ratio),
    .root_select(root_select), .mclk_from_ratio(mclk_from_ratio),
    .mclk_fixed_code(mclk_fixed_code), .mclk_per_frame(mclk_per_frame));

  task automatic test_done;
    if (fails == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Idles a cycle after the strobe so back-to-back calls never retoggle it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    cyc(1);
    chk(12'(reg_rdata), 12'(exp));
  endtask

  task automatic seek(output int n);
    logic p;
    n = 0;
    p = 1'b1;
    while (!(p === 1'b0 && frame_sync_out === 1'b1) && n < 1000) begin
      p = frame_sync_out;
      cyc(1);
      n++;
    end
  endtask

  task automatic t_reset;
    rc(8'h14, 8'h48);
    rc(8'h15, 8'hff);
    rc(8'h16, 8'h10);
    rc(8'h40, 8'h00);
    chk(12'({eff_frame_rate, eff_bitclk_ratio}), 12'h048);
  endtask

  task automatic t_regs;
    wr(8'h15, 8'h00);
    wr(8'h40, 8'h5a);
    rc(8'h15, 8'hff);
    rc(8'h40, 8'h00);
    for (int i = 0; i < 13; i++) begin
      wr(8'h14, {4'(i % 9), 4'(i)});
      chk(12'({eff_frame_rate, eff_bitclk_ratio}), 12'({4'(i % 9), 4'(i)}));
    end
    rc(8'h14, 8'h3c);
  endtask

  task automatic t_source;
    logic [11:0] mrat [8] = '{12'd64, 12'd256, 12'd384, 12'd512,
                              12'd768, 12'd1024, 12'd1536, 12'd2304};
    auto_config_off = 1'b0;
    auto_config_pll_off = 1'b1;
    for (int k = 0; k < 8; k++) begin
      master_clock_fixed_freq = 3'(k);
      wr(8'h16, {1'b1, k[0], 3'(k), 3'b000});
      chk(12'(root_select), 12'(acm_pkg::ACM_ROOT_MCLK));
      chk(12'(mclk_from_ratio), 12'(k % 2));
      chk(mclk_per_frame, mrat[k]);
      chk(12'(mclk_fixed_code), 12'(k));
      rc(8'h16, {1'b1, k[0], 3'(k), 3'b000});
    end
    wr(8'h16, 8'h38);
    chk(12'(root_select), 12'(acm_pkg::ACM_ROOT_BCLK));
    chk(mclk_per_frame, 12'h000);
    auto_config_pll_off = 1'b0;
    bus_role_select = 1'b1;
    cyc(1);
    chk(12'(root_select), 12'(acm_pkg::ACM_ROOT_PLL));
    chk(mclk_per_frame, 12'd2304);
    bus_role_select = 1'b0;
    wr(8'h16, 8'hd0);
    chk(12'(root_select), 12'(acm_pkg::ACM_ROOT_PLL));
    chk(mclk_per_frame, 12'h000);
    chk(12'(mclk_from_ratio), 12'h001);
    auto_config_off = 1'b1;
    cyc(1);
    chk(12'(mclk_from_ratio), 12'h000);
    chk(12'({eff_frame_rate, eff_bitclk_ratio}), 12'h03c);
    auto_config_off = 1'b0;
  endtask

  task automatic t_detect;
    logic [11:0] hv [4] = '{12'd16, 12'd51, 12'd16, 12'd0};
    logic [11:0] bv [4] = '{12'd64, 12'd20, 12'd32, 12'd0};
    logic [7:0]  ev [4] = '{8'h44, 8'hff, 8'h52, 8'hff};
    wr(8'h14, 8'h5c);
    for (int i = 0; i < 4; i++) begin
      h_half = hv[i];
      h_bits = bv[i];
      h_run = (hv[i] != 12'd0);
      cyc(h_run ? 10 * int'(hv[i]) * int'(bv[i]) : 14500);
      rc(8'h15, ev[i]);
      chk(12'({eff_frame_rate, eff_bitclk_ratio}), 12'(ev[i]));
      chk(12'({bclk_oe, frame_sync_oe}), 12'h000);
    end
  endtask

  task automatic t_master;
    int   n;
    logic bc;
    wr(8'h14, 8'h40);
    for (int v = 0; v < 2; v++) begin
      bus_role_select = 1'b0;
      wr(8'h16, 8'h10 | 8'(2 * v));
      bus_role_select = 1'b1;
      seek(n);
      bc = bclk_out;
      seek(n);
      chk(12'(n), 12'(16 * 2 * HALF));
      chk(12'(bc), 12'(v));
      chk(12'({bclk_oe, frame_sync_oe}), 12'h003);
    end
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    t_reset();
    t_regs();
    t_source();
    t_detect();
    t_master();
    test_done();
  end

  initial begin
    repeat (80000) @(posedge clk);
    fails++;
    test_done();
  end
endmodule

bind acm_clock_ctrl acm_clock_ctrl_asserts #(.BCLK_HALF(BCLK_HALF)) u_asserts (.clk(clk),
  .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .bus_role_select(bus_role_select), .auto_config_off(auto_config_off),
  .auto_config_pll_off(auto_config_pll_off), .master_clock_fixed_freq(master_clock_fixed_freq),
  .bclk_in(bclk_in), .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_sync_in(frame_sync_in),
  .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
  .eff_frame_rate(eff_frame_rate), .eff_bitclk_ratio(eff_bitclk_ratio),
  .root_select(root_select), .mclk_from_ratio(mclk_from_ratio),
  .mclk_fixed_code(mclk_fixed_code), .mclk_per_frame(mclk_per_frame));
`default_nettype wire
